// >>> logic/emp_pkg.sv
// Shared constants and carrier types for the external MII port
package emp_pkg;
	// Register indices; a register's byte address is four times its index
	localparam logic [7:0] MGMT_IDX = 8'h14;
	localparam logic [7:0] PST_IDX = 8'h17;
	localparam logic [7:0] CTRL_IDX = 8'h18;
	localparam logic [7:0] TXD_IDX = 8'h19;
	localparam logic [7:0] RXD_IDX = 8'h1a;
	localparam logic [7:0] STAT_IDX = 8'h1b;
	// Management register fields
	localparam int MGMT_MDC_BIT = 0;
	localparam int MGMT_MDO_BIT = 1;
	localparam int MGMT_MDOE_BIT = 2;
	localparam int MGMT_MDI_BIT = 3;
	// PHY status register fields
	localparam int PST_SPEED_BIT = 6;
	localparam int PST_DUPLEX_BIT = 5;
	localparam int PST_LINE_BIT = 4;
	// Control register fields
	localparam int CTRL_SEL_BIT = 0;
	localparam int CTRL_TXGO_BIT = 1;
	// Status register fields
	localparam int STAT_CRS_BIT = 0;
	localparam int STAT_COL_BIT = 1;
	localparam int STAT_TXFULL_BIT = 2;
	localparam int STAT_RXVAL_BIT = 3;
	localparam int STAT_TXBUSY_BIT = 4;
	// Reset values
	localparam logic [3:0] MGMT_RST = 4'h0;
	localparam logic [1:0] CTRL_RST = 2'h0;
	// Management clock limit and fastest legal toggle spacing in pclk cycles
	localparam int MDC_MAX_KHZ = 2500;
	localparam int PCLK_MHZ = 200;
	localparam int MDC_HALF_CYC = (PCLK_MHZ * 1000) / (2 * MDC_MAX_KHZ);
	localparam int FIFO_DEPTH = 4;
	localparam int NIB_W = 4;

	typedef struct packed {
		logic speed;
		logic duplex;
		logic line_up;
	} emp_phy_stat_s;

	typedef struct packed {
		logic tx_clk;
		logic rx_clk;
		logic rx_dv;
		logic [3:0] rxd;
		logic crs;
		logic col;
	} emp_mii_in_s;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SEND = 2'b01,
		TX_LAST = 2'b10
	} emp_tx_e;
endpackage : emp_pkg

// >>> logic/emp_fifo.sv
// Small valid/ready FIFO with combinational read data
`timescale 1ns/1ps
module emp_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rd_ptr_reg];

	always_ff @(posedge pclk) begin
		if (clk_en && push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else if (clk_en) begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : emp_fifo

// >>> logic/emp_port.sv
// External MII port: TX/RX nibble paths, CRS/COL sampling, MDC/MDIO by software
// Function
// (RULE1) RXD sampled on receive clock edges
// (RULE2) Nibbles accepted only while RX_DV high
// (RULE3) No receive-error input; errors ignored
// (RULE4) PHY drives carrier sense asynchronously
// (RULE5) Collision input is the collision indication
// (RULE6) TX_EN changes on rising TX_CLK only
// (RULE7) TXD updated on rising TX_CLK edges
// (RULE8) PHY supplies free-running transmit clock
// (RULE9) PHY supplies free-running receive clock
// (RULE10) MDC pin follows software bit 0
// (RULE11) MDIO bits timed by MDC rising edge
// (RULE12) Software keeps MDC at most 2.5 MHz
// (RULE13) MDIO exchanges follow MII management frames
// (RULE14) Offset 17h bits 6,5,4 report PHY status
// (RULE15) Asynchronous inputs synchronised before use
// (RULE16) MDIO driven only while enable bit set
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module emp_port (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// MII from PHY
	input wire emp_pkg::emp_mii_in_s mii_in,
	// PHY status pins
	input wire emp_pkg::emp_phy_stat_s phy_stat_in,
	// MII to PHY
	output logic tx_en,
	output logic [3:0] txd,
	// Station management
	output logic mdc,
	output logic mdio_o,
	output logic mdio_oe_n,
	input wire logic mdio_i
);
	// Three-stage samplers; stage 2 and 3 must agree before a change counts
	localparam int NS = 12;
	logic [NS-1:0] raw;
	logic [NS-1:0] s1_reg;
	logic [NS-1:0] s2_reg;
	logic [NS-1:0] s3_reg;
	logic [NS-1:0] clean_reg;
	assign raw = {mii_in.tx_clk, mii_in.rx_clk, mii_in.rx_dv, mii_in.rxd,
		mii_in.crs, mii_in.col, phy_stat_in.speed, phy_stat_in.duplex,
		mdio_i};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else if (clk_en) begin
			s1_reg <= raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++) begin : g_filt
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					clean_reg[gi] <= 1'b0;
				end else if (clk_en && (s2_reg[gi] == s3_reg[gi])) begin
					clean_reg[gi] <= s3_reg[gi]; // [RULE15]
				end
			end
		end
	endgenerate

	// Line-up bit sampled separately to keep the vector at twelve
	logic lu1_reg;
	logic lu2_reg;
	logic lu3_reg;
	logic lu_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lu1_reg <= 1'b0;
			lu2_reg <= 1'b0;
			lu3_reg <= 1'b0;
			lu_reg <= 1'b0;
		end else if (clk_en) begin
			lu1_reg <= phy_stat_in.line_up;
			lu2_reg <= lu1_reg;
			lu3_reg <= lu2_reg;
			if (lu2_reg == lu3_reg) begin
				lu_reg <= lu3_reg; // [RULE15]
			end
		end
	end

	logic txc_s;
	logic rxc_s;
	logic rxdv_s;
	logic [3:0] rxd_s;
	logic crs_s;
	logic col_s;
	logic speed_s;
	logic duplex_s;
	logic mdi_s;
	assign {txc_s, rxc_s, rxdv_s, rxd_s, crs_s, col_s, speed_s,
		duplex_s, mdi_s} = clean_reg;

	logic txc_d_reg;
	logic rxc_d_reg;
	logic tx_rise;
	logic rx_rise;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txc_d_reg <= 1'b0;
			rxc_d_reg <= 1'b0;
		end else if (clk_en) begin
			txc_d_reg <= txc_s;
			rxc_d_reg <= rxc_s;
		end
	end
	assign tx_rise = txc_s && !txc_d_reg; // [RULE8]
	assign rx_rise = rxc_s && !rxc_d_reg; // [RULE9]

	// APB decode; registers sit at index*4
	function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction : hit

	logic wr_acc;
	logic rd_acc;
	logic mapped;
	assign wr_acc = psel && penable && pwrite && clk_en;
	assign rd_acc = psel && !penable && !pwrite && clk_en;
	assign mapped = hit(paddr, emp_pkg::MGMT_IDX)
		|| hit(paddr, emp_pkg::PST_IDX) || hit(paddr, emp_pkg::CTRL_IDX)
		|| hit(paddr, emp_pkg::TXD_IDX) || hit(paddr, emp_pkg::RXD_IDX)
		|| hit(paddr, emp_pkg::STAT_IDX);

	logic [3:0] mgmt_reg;
	logic [1:0] ctrl_reg;
	logic [3:0] rxnib_reg;
	logic rxval_reg;
	logic col_seen_reg;

	// Transmit FIFO between software and the TX_CLK-paced sender
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [3:0] fifo_out_data;
	logic fifo_pop;
	// Push only on the accepting edge, so a stalled write lands once
	assign fifo_in_valid = wr_acc && pready
		&& hit(paddr, emp_pkg::TXD_IDX);

	emp_fifo #(
		.WIDTH(emp_pkg::NIB_W),
		.DEPTH(emp_pkg::FIFO_DEPTH)
	) u_txfifo (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.in_valid(fifo_in_valid),
		.in_data(pwdata[3:0]),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(fifo_pop)
	);

	// Writes to a full FIFO stall the bus instead of dropping data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			if (psel && !penable) begin
				pready <= !(pwrite && hit(paddr, emp_pkg::TXD_IDX)
					&& !fifo_in_ready);
				pslverr <= !mapped;
			end else if (psel && penable && !pready) begin
				pready <= fifo_in_ready;
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mgmt_reg <= emp_pkg::MGMT_RST;
		end else if (wr_acc && pready && hit(paddr, emp_pkg::MGMT_IDX)) begin
			mgmt_reg <= pwdata[3:0]; // [RULE10] [RULE12] [RULE16]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= emp_pkg::CTRL_RST;
		end else if (wr_acc && pready && hit(paddr, emp_pkg::CTRL_IDX)) begin
			ctrl_reg <= pwdata[1:0];
		end
	end

	// Receive path: one nibble per RX_CLK rise while RX_DV; no error input
	logic rd_rx;
	assign rd_rx = psel && penable && pready && !pwrite && clk_en
		&& hit(paddr, emp_pkg::RXD_IDX);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxnib_reg <= 4'h0;
			rxval_reg <= 1'b0;
		end else if (clk_en) begin
			if (ctrl_reg[emp_pkg::CTRL_SEL_BIT] && rx_rise && rxdv_s) begin
				rxnib_reg <= rxd_s; // [RULE1] [RULE2] [RULE3]
				rxval_reg <= 1'b1;
			end else if (rd_rx) begin
				rxval_reg <= 1'b0;
			end
		end
	end

	// Sticky collision flag; a new collision wins over the clearing read
	logic rd_stat;
	assign rd_stat = psel && penable && pready && !pwrite && clk_en
		&& hit(paddr, emp_pkg::STAT_IDX);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			col_seen_reg <= 1'b0;
		end else if (clk_en) begin
			if (col_s) begin
				col_seen_reg <= 1'b1; // [RULE5]
			end else if (rd_stat) begin
				col_seen_reg <= 1'b0;
			end
		end
	end

	// Transmit sender, paced by sampled TX_CLK rises
	emp_pkg::emp_tx_e tx_state_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state_reg <= emp_pkg::TX_IDLE;
			tx_en <= 1'b0;
			txd <= 4'h0;
		end else if (clk_en && tx_rise) begin
			case (tx_state_reg)
			emp_pkg::TX_IDLE: begin
				if (fifo_out_valid && ctrl_reg[emp_pkg::CTRL_TXGO_BIT]
					&& ctrl_reg[emp_pkg::CTRL_SEL_BIT]) begin
					tx_en <= 1'b1; // [RULE6]
					txd <= fifo_out_data; // [RULE7]
					tx_state_reg <= emp_pkg::TX_SEND;
				end
			end
			emp_pkg::TX_SEND: begin
				if (fifo_out_valid) begin
					txd <= fifo_out_data; // [RULE7]
				end else begin
					tx_en <= 1'b0; // [RULE6]
					txd <= 4'h0;
					tx_state_reg <= emp_pkg::TX_IDLE;
				end
			end
			default: begin
				tx_en <= 1'b0;
				tx_state_reg <= emp_pkg::TX_IDLE;
			end
			endcase
		end
	end
	assign fifo_pop = clk_en && tx_rise && fifo_out_valid
		&& (tx_state_reg == emp_pkg::TX_SEND
		|| (tx_state_reg == emp_pkg::TX_IDLE
		&& ctrl_reg[emp_pkg::CTRL_TXGO_BIT]
		&& ctrl_reg[emp_pkg::CTRL_SEL_BIT]));

	// Management pins follow software bits; framing and rate are software's
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mdc <= 1'b0;
			mdio_o <= 1'b0;
			mdio_oe_n <= 1'b1;
		end else if (clk_en) begin
			mdc <= mgmt_reg[emp_pkg::MGMT_MDC_BIT]; // [RULE10] [RULE11]
			mdio_o <= mgmt_reg[emp_pkg::MGMT_MDO_BIT]; // [RULE13]
			mdio_oe_n <= !mgmt_reg[emp_pkg::MGMT_MDOE_BIT]; // [RULE16]
		end
	end

	// Read data, registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_acc) begin
			prdata <= 32'h0000_0000;
			if (hit(paddr, emp_pkg::MGMT_IDX)) begin
				prdata[3:0] <= {mdi_s, mgmt_reg[2:0]}; // [RULE16]
			end
			if (hit(paddr, emp_pkg::PST_IDX)
				&& ctrl_reg[emp_pkg::CTRL_SEL_BIT]) begin
				prdata[emp_pkg::PST_SPEED_BIT] <= speed_s; // [RULE14]
				prdata[emp_pkg::PST_DUPLEX_BIT] <= duplex_s; // [RULE14]
				prdata[emp_pkg::PST_LINE_BIT] <= lu_reg; // [RULE14]
			end
			if (hit(paddr, emp_pkg::CTRL_IDX)) begin
				prdata[1:0] <= ctrl_reg;
			end
			if (hit(paddr, emp_pkg::RXD_IDX)) begin
				prdata[3:0] <= rxnib_reg;
			end
			if (hit(paddr, emp_pkg::STAT_IDX)) begin
				prdata[emp_pkg::STAT_CRS_BIT] <= crs_s; // [RULE4]
				prdata[emp_pkg::STAT_COL_BIT] <= col_seen_reg;
				prdata[emp_pkg::STAT_TXFULL_BIT] <= !fifo_in_ready;
				prdata[emp_pkg::STAT_RXVAL_BIT] <= rxval_reg;
				prdata[emp_pkg::STAT_TXBUSY_BIT] <= tx_en;
			end
		end
	end
endmodule : emp_port

// >>> bench/emp_port_asserts.sv
// Checker for the external MII port, bound to its ports
`timescale 1ns/1ps
module emp_port_asserts (
	// Bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire emp_pkg::emp_mii_in_s mii_in,
	input wire emp_pkg::emp_phy_stat_s phy_stat_in,
	input wire logic tx_en,
	input wire logic [3:0] txd,
	input wire logic mdc,
	input wire logic mdio_o,
	input wire logic mdio_oe_n,
	input wire logic mdio_i
);
	logic acc;
	logic mg_wr;
	logic [4:0] watch;
	logic [3:0] since_reg;
	logic [3:0] stab_reg;
	logic [1:0] ctrl_reg;
	logic [7:0] mdc_gap_reg;
	assign acc = psel && penable && pready;
	assign mg_wr = acc && pwrite && paddr == 10'h050;
	assign watch = {phy_stat_in, mdio_i, mii_in.crs};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Pclk cycles since the sampled transmit clock last rose
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_reg <= 4'hf;
		end else if ($rose(mii_in.tx_clk)) begin
			since_reg <= 4'h0;
		end else if (since_reg != 4'hf) begin
			since_reg <= since_reg + 4'h1;
		end
	end
	// Slow pins must settle through the synchronisers before a read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stab_reg <= 4'h0;
		end else if ($changed(watch)) begin
			stab_reg <= 4'h0;
		end else if (stab_reg != 4'hf) begin
			stab_reg <= stab_reg + 4'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= 2'h0;
		end else if (acc && pwrite && paddr == 10'h060) begin
			ctrl_reg <= pwdata[1:0];
		end
	end
	// Cycles since mdc last moved, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mdc_gap_reg <= 8'hff;
		end else if ($changed(mdc)) begin
			mdc_gap_reg <= 8'h01;
		end else if (mdc_gap_reg != 8'hff) begin
			mdc_gap_reg <= mdc_gap_reg + 8'h01;
		end
	end
	property p_mdc_rate;
		$changed(mdc) |-> mdc_gap_reg >= emp_pkg::MDC_HALF_CYC;
	endproperty
	a_mdc_rate: assert property (p_mdc_rate)
		else $error("mdc too fast");
	// Pins follow the register one cycle after the write lands
	property p_mdc; mg_wr |-> ##2 mdc == $past(pwdata[0], 2); endproperty
	a_mdc: assert property (p_mdc) else $error("mdc wrong");
	property p_mdc_hold; !mg_wr ##1 !mg_wr |=> $stable(mdc); endproperty
	a_mdc_hold: assert property (p_mdc_hold) else $error("mdc moved");
	property p_mdio;
		mg_wr |-> ##2 mdio_oe_n == !$past(pwdata[2], 2)
			&& mdio_o == $past(pwdata[1], 2);
	endproperty
	a_mdio: assert property (p_mdio) else $error("mdio drive wrong");
	property p_mdi;
		acc && !pwrite && paddr == 10'h050 && stab_reg > 4'h9
		|-> prdata[3] == mdio_i;
	endproperty
	a_mdi: assert property (p_mdi) else $error("mdio read wrong");
	property p_phy_stat;
		acc && !pwrite && paddr == 10'h05c && stab_reg > 4'h9
		|-> prdata[6:4] == (ctrl_reg[0] ? phy_stat_in : 3'h0);
	endproperty
	a_phy_stat: assert property (p_phy_stat) else $error("status wrong");
	property p_crs;
		acc && !pwrite && paddr == 10'h06c && stab_reg > 4'h9
		|-> prdata[0] == mii_in.crs;
	endproperty
	a_crs: assert property (p_crs) else $error("carrier wrong");
	property p_tx_en; $changed(tx_en) |-> since_reg < 4'ha; endproperty
	a_tx_en: assert property (p_tx_en) else $error("tx_en off edge");
	property p_txd; $changed(txd) |-> since_reg < 4'ha; endproperty
	a_txd: assert property (p_txd) else $error("txd off edge");
	property p_tx_go; $rose(tx_en) |-> ctrl_reg == 2'h3; endproperty
	a_tx_go: assert property (p_tx_go) else $error("tx not enabled");
endmodule : emp_port_asserts

bind emp_port emp_port_asserts emp_port_asserts_inst (.*);

// >>> bench/emp_phy_model.sv
// Behavioural PHY at the far side of the MII port
`timescale 1ns/1ps
module emp_phy_model (
	// From the port
	input wire logic tx_en,
	input wire logic [3:0] txd,
	// To the port
	output emp_pkg::emp_mii_in_s mii_in
);
	logic tck = 1'b0;
	logic rck = 1'b0;
	logic dv = 1'b0;
	logic [3:0] rd = 4'hf;
	logic crs = 1'b0;
	logic col = 1'b0;
	logic [3:0] tx_q[$];
	assign mii_in = '{tck, rck, dv, rd, crs, col};
	// Free-running clocks, unrelated in phase to pclk and to each other
	initial begin
		#7;
		forever #32 tck = ~tck;
	end
	initial begin
		#19;
		forever #32 rck = ~rck;
	end
	always @(posedge tck) begin
		if (tx_en === 1'b1) begin
			tx_q.push_back(txd);
		end
	end
	// Data change on the falling edge; idle lines float to the pull-up
	task send(input logic [3:0] n);
		@(negedge rck);
		dv = 1'b1;
		rd = n;
		@(negedge rck);
		dv = 1'b0;
		rd = 4'hf;
	endtask : send
endmodule : emp_phy_model

// >>> bench/testbench.sv
// Self-checking bench for the external MII port
`timescale 1ns/1ps
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, tx_en, mdc, mdio_o, mdio_oe_n;
	logic [3:0] txd;
	logic md_phy = 1'b1;
	logic mdio_w;
	emp_pkg::emp_mii_in_s mii_in;
	emp_pkg::emp_phy_stat_s stat = 3'h0;
	logic [31:0] rd;
	logic er;
	int fails = 0;
	int cmp_count = 0;
	// Shared MDIO wire: port drives while enable is low
	assign mdio_w = mdio_oe_n ? md_phy : mdio_o;
	initial begin
		forever #2.5 pclk = ~pclk;
	end
	emp_port emp_port_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mii_in(mii_in), .phy_stat_in(stat), .tx_en(tx_en), .txd(txd),
		.mdc(mdc), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .mdio_i(mdio_w));
	emp_phy_model emp_phy_model_inst (.tx_en(tx_en), .txd(txd),
		.mii_in(mii_in));
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Request holds until pready is seen high at a rising edge
	task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 500);
		if (n >= 500) begin
			fails++;
			end_sim;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task end_sim;
		$display("Compares %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	task t_mgmt;
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, 10'h050, i);
			// Keeps mdc half periods no shorter than the fastest legal spacing
			repeat (40) @(negedge pclk);
			chk("mgmt pins", {29'h0, !i[2], i[1:0]}, {29'h0, mdio_oe_n, mdio_o, mdc});
		end
		apb(1'b1, 10'h050, 32'h0);
		md_phy <= 1'b0;
		repeat (12) @(posedge pclk);
		apb(1'b0, 10'h050, 32'h0);
		chk("mdio low", 32'h0, rd);
		md_phy <= 1'b1;
		repeat (12) @(posedge pclk);
		apb(1'b0, 10'h050, 32'h0);
		chk("mdio high", 32'h8, rd);
		$display("mgmt test done");
	endtask : t_mgmt
	task t_phy_status;
		stat <= 3'h5;
		apb(1'b1, 10'h060, 32'h0);
		repeat (12) @(posedge pclk);
		apb(1'b0, 10'h05c, 32'h0);
		chk("status unsel", 32'h0, rd);
		apb(1'b1, 10'h060, 32'h1);
		apb(1'b0, 10'h05c, 32'h0);
		chk("status 5", 32'h50, rd);
		stat <= 3'h2;
		repeat (12) @(posedge pclk);
		apb(1'b0, 10'h05c, 32'h0);
		chk("status 2", 32'h20, rd);
		$display("status test done");
	endtask : t_phy_status
	task t_tx;
		int n;
		apb(1'b1, 10'h064, 32'ha);
		apb(1'b1, 10'h064, 32'h5);
		apb(1'b1, 10'h064, 32'hc);
		apb(1'b1, 10'h064, 32'h3);
		apb(1'b0, 10'h06c, 32'h0);
		chk("tx full", 32'h4, rd & 32'h14);
		apb(1'b1, 10'h060, 32'h3);
		n = 0;
		while (emp_phy_model_inst.tx_q.size() < 4 && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		repeat (40) @(posedge pclk);
		chk("tx nibbles", 32'ha5c3, {16'h0, emp_phy_model_inst.tx_q[0],
			emp_phy_model_inst.tx_q[1], emp_phy_model_inst.tx_q[2],
			emp_phy_model_inst.tx_q[3]});
		chk("tx count", 32'h4, emp_phy_model_inst.tx_q.size());
		chk("tx end", 32'h0, {31'h0, tx_en});
		apb(1'b1, 10'h060, 32'h1);
		$display("transmit test done");
	endtask : t_tx
	task t_rx;
		emp_phy_model_inst.send(4'h9);
		repeat (40) @(posedge pclk);
		apb(1'b0, 10'h06c, 32'h0);
		chk("rx valid", 32'h8, rd & 32'h8);
		apb(1'b0, 10'h068, 32'h0);
		chk("rx nibble", 32'h9, rd);
		repeat (60) @(posedge pclk);
		apb(1'b0, 10'h06c, 32'h0);
		chk("rx idle", 32'h0, rd & 32'h8);
		$display("receive test done");
	endtask : t_rx
	task t_crs;
		emp_phy_model_inst.crs <= 1'b1;
		emp_phy_model_inst.col <= 1'b1;
		repeat (20) @(posedge pclk);
		emp_phy_model_inst.col <= 1'b0;
		repeat (20) @(posedge pclk);
		apb(1'b0, 10'h06c, 32'h0);
		chk("crs col", 32'h3, rd & 32'h3);
		apb(1'b0, 10'h06c, 32'h0);
		chk("col clear", 32'h1, rd & 32'h3);
		emp_phy_model_inst.crs <= 1'b0;
		apb(1'b0, 10'h3fc, 32'h0);
		chk("unmapped", 32'h1, {rd[30:0], er});
		$display("carrier test done");
	endtask : t_crs
	initial begin
		#200000;
		fails++;
		$display("CHECK FAILED watchdog exp 1 got 0");
		end_sim;
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk("reset pins", 32'h4, {28'h0, tx_en, mdio_oe_n, mdio_o, mdc});
		t_mgmt;
		t_phy_status;
		t_tx;
		t_rx;
		t_crs;
		end_sim;
	end
endmodule : testbench
